// ---- design/rxeif_pkg.sv ----
// rxeif_pkg: shared constants for the receive early-interrupt and flow control block
// assumes an AXI4-Lite register bus with 32-bit data and a 25 MHz core clock
package rxeif_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] RXEIF_REG_CTRL = 8'h18;
  localparam logic [7:0] RXEIF_REG_STAT = 8'h1C;
  localparam logic [7:0] RXEIF_REG_CFG = 8'h20;
  localparam int RXEIF_ERI_LSB = 0;
  localparam int RXEIF_TH_LSB = 8;
  localparam int RXEIF_XON_BIT = 16;
  localparam int RXEIF_XOFF_BIT = 17;
  localparam int RXEIF_FULL_BIT = 18;
  localparam int RXEIF_PAUSE_BIT = 19;
  localparam int RXEIF_PLOW_BIT = 20;
  localparam logic [7:0] RXEIF_ERI_RST = 8'h00;
  localparam logic [2:0] RXEIF_TH_RST = 3'h0;
  // ==========================================================
  // frame parsing
  localparam logic [15:0] RXEIF_MAX_LEN = 16'h05DC;
  localparam logic [15:0] RXEIF_TYPE_IPX = 16'h8137;
  localparam logic [15:0] RXEIF_TYPE_IP = 16'h0800;
  localparam logic [5:0] RXEIF_TL_HI = 6'h0C;
  localparam logic [5:0] RXEIF_TL_LO = 6'h0D;
  localparam logic [5:0] RXEIF_IPL_HI = 6'h10;
  localparam logic [5:0] RXEIF_IPL_LO = 6'h11;
  localparam logic [5:0] RXEIF_HDR_DONE = 6'h12;
  localparam logic [15:0] RXEIF_HDR_LEN = 16'h000E;
  // ==========================================================
  // flow control thresholds in bytes, and timer
  localparam logic [11:0] RXEIF_TH_BASE = 12'h200;
  localparam logic [11:0] RXEIF_TH_STEP = 12'h100;
  localparam logic [11:0] RXEIF_TH_ONE = 12'h400;
  localparam logic [15:0] RXEIF_TMR_ZERO = 16'h0000;
  typedef enum logic [1:0] {RXEIF_IDLE, RXEIF_HDR, RXEIF_BODY, RXEIF_SKIP} rxeif_st_t;
endpackage

// ---- design/rxeif_top.sv ----
// rxeif_top: early receive interrupt engine and flow control register
// assumes receive bytes arrive as one-cycle strobes and pause events as pulses
`timescale 1ns/1ns
module rxeif_top
  import rxeif_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_sof,
  input wire logic rx_byte_vld,
  input wire logic [7:0] rx_byte,
  input wire logic rx_eof,
  input wire logic rx_bad,
  input wire logic rx_overflow,
  input wire logic receive_unit_ready,
  input wire logic descriptor_pause_bit,
  input wire logic pause_rx,
  input wire logic pause_low_rx,
  input wire logic [15:0] pause_value,
  input wire logic pause_tick,
  input wire logic [11:0] fifo_free,
  output logic early_rx_event_flag,
  output logic frame_received_flag,
  output logic inta_n,
  output logic descriptor_reclaim,
  output logic pause_tx_req
);
  // ==========================================================
  // registers
  logic [7:0] eri_r;
  logic [2:0] th_r;
  logic ipx_en_r, ip_en_r, save_bad_r;
  logic xoff_r, plow_r, paused_r, full_r;
  logic [15:0] tmr_r;
  logic er_r, fr_r;
  logic aw_hold_r, w_hold_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  rxeif_st_t st_r;
  logic [15:0] cnt_r, len_r;
  logic [7:0] hi_r;
  logic fired_r, first_r, armed_r;

  // threshold code to free-byte count; code 0 is the odd one
  function automatic logic [11:0] th_bytes(input logic [2:0] c);
    if (c == 3'h0) begin
      th_bytes = RXEIF_TH_BASE;
    end else begin
      th_bytes = 12'(RXEIF_TH_ONE + 12'(c - 3'h1) * RXEIF_TH_STEP);
    end
  endfunction

  // ==========================================================
  // axi write path: address and data captured in either order
  wire wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
  wire wr_ctrl = wr_go && awaddr_r == RXEIF_REG_CTRL;
  wire wr_cfg = wr_go && awaddr_r == RXEIF_REG_CFG;
  wire wr_known = awaddr_r == RXEIF_REG_CTRL || awaddr_r == RXEIF_REG_STAT ||
                  awaddr_r == RXEIF_REG_CFG;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (clk_en) begin
      s_axi_awready <= !aw_hold_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_hold_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? 2'h0 : 2'h2; // slverr on unmapped
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // software fields: early threshold, fifo threshold, options
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eri_r <= RXEIF_ERI_RST;
      th_r <= RXEIF_TH_RST;
      ipx_en_r <= 1'b0;
      ip_en_r <= 1'b0;
      save_bad_r <= 1'b0;
    end else if (clk_en) begin
      if (wr_ctrl && wstrb_r[0]) begin
        eri_r <= wdata_r[7:0];
      end
      if (wr_ctrl && wstrb_r[1]) begin
        th_r <= wdata_r[RXEIF_TH_LSB +: 3];
      end
      if (wr_cfg && wstrb_r[0]) begin
        ipx_en_r <= wdata_r[0];
        ip_en_r <= wdata_r[1];
        save_bad_r <= wdata_r[2];
      end
    end
  end

  // ==========================================================
  // axi read path, one-cycle answer after the address is taken
  wire [31:0] ctrl_rd = {8'h00, 3'h0, plow_r, paused_r, full_r, xoff_r, 1'b0,
                         5'h00, th_r, eri_r};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (clk_en) begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case ({s_axi_araddr[7:2], 2'h0})
          RXEIF_REG_CTRL: s_axi_rdata <= ctrl_rd;
          RXEIF_REG_STAT: s_axi_rdata <= {30'h0, fr_r, er_r};
          RXEIF_REG_CFG: s_axi_rdata <= {29'h0, save_bad_r, ip_en_r, ipx_en_r};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // frame parser: counts bytes, learns length from header
  // lengths are held as byte counts including the 14-byte header, so the
  // remaining-byte test needs no correction at the end of the frame
  wire [15:0] tl_word = {hi_r, rx_byte};
  wire [15:0] ery_bytes = {5'h00, eri_r, 3'h0};
  wire [15:0] remain = (len_r > cnt_r) ? 16'(len_r - cnt_r) : 16'h0000;
  wire early_hit = st_r == RXEIF_BODY && armed_r && !fired_r && eri_r != 8'h00 &&
                   receive_unit_ready && !rx_overflow &&
                   (remain <= ery_bytes || ery_bytes >= len_r);
  wire stat_clr = wr_go && awaddr_r == RXEIF_REG_STAT;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= RXEIF_IDLE;
      cnt_r <= 16'h0000;
      len_r <= 16'h0000;
      hi_r <= 8'h00;
      fired_r <= 1'b0;
      first_r <= 1'b1;
    end else if (clk_en) begin
      if (eri_r == 8'h00) begin
        first_r <= 1'b1;
      end
      case (st_r)
        RXEIF_IDLE: begin
          if (rx_sof) begin
            cnt_r <= 16'h0000;
            fired_r <= 1'b0;
            // the very first frame after enabling is skipped
            st_r <= (receive_unit_ready && !first_r) ? RXEIF_HDR : RXEIF_SKIP;
            if (eri_r != 8'h00) begin
              first_r <= 1'b0;
            end
          end
        end
        RXEIF_HDR: begin
          if (rx_byte_vld) begin
            cnt_r <= 16'(cnt_r + 16'h0001);
            hi_r <= rx_byte;
            if (cnt_r[5:0] == RXEIF_TL_LO) begin
              if (tl_word != 16'h0000 && tl_word <= RXEIF_MAX_LEN) begin
                len_r <= 16'(tl_word + RXEIF_HDR_LEN);
                st_r <= RXEIF_BODY;
              end else if (!((tl_word == RXEIF_TYPE_IPX && ipx_en_r) ||
                             (tl_word == RXEIF_TYPE_IP && ip_en_r))) begin
                st_r <= RXEIF_SKIP;
              end
            end
            if (cnt_r[5:0] == RXEIF_IPL_LO) begin
              len_r <= 16'(tl_word + RXEIF_HDR_LEN);
              st_r <= RXEIF_BODY;
            end
          end
          if (rx_eof) begin
            st_r <= RXEIF_IDLE;
          end
        end
        RXEIF_BODY: begin
          if (rx_byte_vld) begin
            cnt_r <= 16'(cnt_r + 16'h0001);
          end
          if (early_hit) begin
            fired_r <= 1'b1;
          end
          if (rx_overflow) begin
            st_r <= RXEIF_SKIP;
          end
          if (rx_eof) begin
            st_r <= RXEIF_IDLE;
          end
        end
        RXEIF_SKIP: begin
          if (rx_eof) begin
            st_r <= RXEIF_IDLE;
          end
        end
        default: st_r <= RXEIF_IDLE;
      endcase
    end
  end
  // armed once the length is known; a short frame ends before reaching the mark
  assign armed_r = len_r != 16'h0000;

  // ==========================================================
  // status flags and interrupt; a set wins over a software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      er_r <= 1'b0;
      fr_r <= 1'b0;
      early_rx_event_flag <= 1'b0;
      frame_received_flag <= 1'b0;
      inta_n <= 1'b1;
      descriptor_reclaim <= 1'b0;
    end else if (clk_en) begin
      if (early_hit) begin
        er_r <= 1'b1;
      end else if (stat_clr && wdata_r[0]) begin
        er_r <= 1'b0;
      end
      // discard mode drops the frame-received report for errored frames
      if (rx_eof && st_r != RXEIF_IDLE && !(rx_bad && !save_bad_r)) begin
        fr_r <= 1'b1;
      end else if (stat_clr && wdata_r[1]) begin
        fr_r <= 1'b0;
      end
      descriptor_reclaim <= rx_eof && rx_bad && !save_bad_r;
      early_rx_event_flag <= er_r;
      frame_received_flag <= fr_r;
      inta_n <= !(er_r || fr_r);
    end
  end

  // ==========================================================
  // flow control state
  wire xon_wr = wr_ctrl && wstrb_r[2] && wdata_r[RXEIF_XON_BIT];
  wire xoff_wr = wr_ctrl && wstrb_r[2] && wdata_r[RXEIF_XOFF_BIT];
  wire fifo_hit = fifo_free <= th_bytes(th_r);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xoff_r <= 1'b0;
      full_r <= 1'b0;
      pause_tx_req <= 1'b0;
    end else if (clk_en) begin
      // a fresh request beats a simultaneous clear
      if (xoff_wr || descriptor_pause_bit) begin
        xoff_r <= 1'b1;
      end else if (xon_wr) begin
        xoff_r <= 1'b0;
      end
      full_r <= xoff_r || fifo_hit;
      pause_tx_req <= xoff_r || fifo_hit;
    end
  end

  // pause timer loaded by received pause frames
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tmr_r <= RXEIF_TMR_ZERO;
      paused_r <= 1'b0;
      plow_r <= 1'b0;
    end else if (clk_en) begin
      if ((pause_rx || pause_low_rx) && pause_value != RXEIF_TMR_ZERO) begin
        tmr_r <= pause_value;
        paused_r <= pause_rx;
        plow_r <= pause_low_rx;
      end else if (pause_rx) begin
        plow_r <= 1'b0;
      end else if (pause_tick && tmr_r != RXEIF_TMR_ZERO) begin
        tmr_r <= 16'(tmr_r - 16'h0001);
        if (tmr_r == 16'h0001) begin
          paused_r <= 1'b0;
          plow_r <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // checks
  // software request without a same-cycle clear
  sequence xoff_write_s;
    clk_en && xoff_wr && !xon_wr;
  endsequence
  xoff_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    xoff_write_s |=> xoff_r) else $error("xoff not set");
  xon_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && xon_wr && !xoff_wr && !descriptor_pause_bit |=> !xoff_r)
    else $error("xon did not clear");
  full_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && xoff_r |=> full_r) else $error("full flag missing");
  // watched on the flag itself, so a broken gate in the hit term shows up here
  zero_thr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && eri_r == 8'h00 && !er_r |=> !er_r) else $error("early irq with zero threshold");
  // early event in three steps: the hit, the status flag, then the line low
  sequence early_hit_s;
    clk_en && early_hit;
  endsequence
  sequence early_flag_s;
    er_r;
  endsequence
  sequence irq_low_s;
    !clk_en || !inta_n;
  endsequence
  early_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    early_hit_s |=> early_flag_s ##1 irq_low_s)
    else $error("early event lost");
  ru_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && !receive_unit_ready && !er_r |=> !er_r)
    else $error("early irq while unit stopped");
  timer_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && pause_tick && tmr_r == 16'h0001 && !pause_rx && !pause_low_rx |=> !paused_r)
    else $error("pause flag stuck");
  plow_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && pause_rx && !pause_low_rx |=> !plow_r) else $error("pause low not cleared");
  bit16_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> !s_axi_rdata[RXEIF_XON_BIT])
    else $error("bit 16 reads one");
  // descriptor handback follows the end of an errored frame only in discard mode
  reclaim_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && rx_eof && rx_bad && !save_bad_r |=> descriptor_reclaim)
    else $error("errored frame not reclaimed");
  save_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && save_bad_r |=> !descriptor_reclaim)
    else $error("descriptor reclaimed in save mode");
  frame_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && rx_eof && !rx_bad && st_r != RXEIF_IDLE |=> fr_r)
    else $error("frame end not reported");
  fifo_pause_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && fifo_hit |=> pause_tx_req)
    else $error("no pause at fifo threshold");
endmodule

// ---- verif/rxeif_rx_model.sv ----
// rxeif_rx_model: receive byte source standing in for the MAC front end
// assumes one clock domain; the bench calls send_frame between frames only
`timescale 1ns/1ns
module rxeif_rx_model (
  input wire logic aclk,
  output logic rx_sof,
  output logic rx_byte_vld,
  output logic [7:0] rx_byte,
  output logic rx_eof,
  output logic rx_bad
);
  // idle state at time zero
  initial begin
    rx_sof = 1'b0;
    rx_byte_vld = 1'b0;
    rx_byte = 8'h00;
    rx_eof = 1'b0;
    rx_bad = 1'b0;
  end
  // ==========================================================
  // frame: type/length in bytes 13-14, packet length in 17-18
  // idle byte lines in a gap show the inverse of the last byte; with no gap they keep the last byte after the frame
  task automatic send_frame(input logic [15:0] tl, input logic [15:0] ipl, input int n,
    input logic bad, input int gap);
    logic [7:0] b;
    @(posedge aclk);
    rx_sof <= 1'b1;
    @(posedge aclk);
    rx_sof <= 1'b0;
    for (int i = 0; i < n; i++) begin
      b = (i == 12) ? tl[15:8] : (i == 13) ? tl[7:0] : (i == 16) ? ipl[15:8] :
        (i == 17) ? ipl[7:0] : 8'($urandom);
      rx_byte_vld <= 1'b1;
      rx_byte <= b;
      @(posedge aclk);
      if (gap > 0) begin
        rx_byte_vld <= 1'b0;
        rx_byte <= ~b;
        repeat (gap) @(posedge aclk);
      end
    end
    // bad level is only meaningful with the end strobe
    rx_byte_vld <= 1'b0;
    rx_eof <= 1'b1;
    rx_bad <= bad;
    @(posedge aclk);
    rx_eof <= 1'b0;
    rx_bad <= 1'b0;
  endtask
endmodule

// ---- verif/tb_rxeif_top.sv ----
// tb_rxeif_top: self-checking bench for the early receive and flow control block
// assumes the AXI4-Lite map at 18h/1Ch/20h and the model above as frame source
`timescale 1ns/1ns
module tb_rxeif_top;
  import rxeif_pkg::*;
  typedef struct packed {
    logic [15:0] tl;
    logic [15:0] ipl;
    logic [7:0] n;
    logic [2:0] cfg;
    logic ru;
    logic [7:0] thr;
    logic bad;
    logic er;
  } rxeif_case_t;
  localparam rxeif_case_t CASES [11] = '{
    '{16'h002E, 16'h0000, 8'h3C, 3'h0, 1'b1, 8'h02, 1'b0, 1'b1},
    '{16'h0806, 16'h0000, 8'h3C, 3'h0, 1'b1, 8'h02, 1'b0, 1'b0},
    '{16'h0800, 16'h002E, 8'h3C, 3'h2, 1'b1, 8'h02, 1'b0, 1'b1},
    '{16'h8137, 16'h002E, 8'h3C, 3'h2, 1'b1, 8'h02, 1'b0, 1'b0},
    '{16'h8137, 16'h002E, 8'h3C, 3'h1, 1'b1, 8'h02, 1'b0, 1'b1},
    '{16'h002E, 16'h0000, 8'h1E, 3'h0, 1'b1, 8'h02, 1'b0, 1'b0},
    '{16'h002E, 16'h0000, 8'h3C, 3'h0, 1'b1, 8'h0A, 1'b0, 1'b1},
    '{16'h002E, 16'h0000, 8'h3C, 3'h0, 1'b1, 8'h02, 1'b1, 1'b1},
    '{16'h002E, 16'h0000, 8'h3C, 3'h4, 1'b1, 8'h02, 1'b1, 1'b1},
    '{16'h002E, 16'h0000, 8'h3C, 3'h0, 1'b0, 8'h02, 1'b0, 1'b0},
    '{16'h002E, 16'h0000, 8'h3C, 3'h0, 1'b1, 8'h00, 1'b0, 1'b0}};
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic rx_sof, rx_byte_vld, rx_eof, rx_bad, receive_unit_ready, descriptor_pause_bit;
  logic clk_en, rx_overflow;
  logic [3:0] s_axi_wstrb;
  logic [7:0] rx_byte;
  logic pause_rx, pause_low_rx, pause_tick, early_rx_event_flag, frame_received_flag;
  logic inta_n, descriptor_reclaim, pause_tx_req;
  logic [15:0] pause_value;
  logic [11:0] fifo_free, th;
  int n_errors, comparisons, n_recl;
  rxeif_case_t c;
  rxeif_top rxeif_top_inst (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rx_sof(rx_sof),
    .rx_byte_vld(rx_byte_vld), .rx_byte(rx_byte), .rx_eof(rx_eof), .rx_bad(rx_bad),
    .rx_overflow(rx_overflow), .receive_unit_ready(receive_unit_ready),
    .descriptor_pause_bit(descriptor_pause_bit), .pause_rx(pause_rx),
    .pause_low_rx(pause_low_rx), .pause_value(pause_value), .pause_tick(pause_tick),
    .fifo_free(fifo_free), .early_rx_event_flag(early_rx_event_flag),
    .frame_received_flag(frame_received_flag), .inta_n(inta_n),
    .descriptor_reclaim(descriptor_reclaim), .pause_tx_req(pause_tx_req));
  rxeif_rx_model rxeif_rx_model_inst (.aclk(aclk), .rx_sof(rx_sof), .rx_byte_vld(rx_byte_vld),
    .rx_byte(rx_byte), .rx_eof(rx_eof), .rx_bad(rx_bad));
  // ==========================================================
  // clock, reclaim pulse counter, and a watchdog against a hung handshake
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (descriptor_reclaim === 1'b1) n_recl++;
  end
  initial begin
    repeat (40000) @(posedge aclk);
    n_errors++;
    end_of_test();
  end
  // ==========================================================
  // comparison, verdict and bus tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // address and data are offered together and dropped one by one as taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw = 1'b0;
    w = 1'b0;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // single-cycle pause event from the receive side
  task automatic pulse(input logic low, input logic [15:0] v);
    @(posedge aclk);
    pause_rx <= ~low;
    pause_low_rx <= low;
    pause_value <= v;
    @(posedge aclk);
    pause_rx <= 1'b0;
    pause_low_rx <= 1'b0;
  endtask
  // free-space threshold: half a kilobyte, then one kilobyte up in quarter steps
  function automatic logic [11:0] th_bytes(input logic [2:0] code);
    return (code == 3'h0) ? 12'h200 : 12'h400 + 12'(code - 3'h1) * 12'h100;
  endfunction
  // ==========================================================
  // main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {receive_unit_ready, descriptor_pause_bit, pause_rx, pause_low_rx, pause_tick} = 5'h00;
    {pause_value, fifo_free} = 28'h0;
    {n_errors, comparisons, n_recl} = 96'h0;
    {clk_en, rx_overflow, s_axi_wstrb} = 6'h2F;
    fifo_free = 12'hFFF;
    aresetn = 1'b0;
    void'($urandom(19));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(RXEIF_REG_CTRL);
    chk("ctrl reset", d, 32'h0);
    chk("inta reset", inta_n, 1'b1);
    rd(8'h40);
    chk("unmapped data", d, 32'h0);
    chk("unmapped resp", 32'(r), 32'h2);
    $display("test reset done");
    // every threshold code: read back, then pause request at exactly the free-space limit
    for (int k = 0; k < 8; k++) begin
      c.thr = 8'($urandom);
      th = th_bytes(3'(k));
      fifo_free <= th + 12'h001;
      wr(RXEIF_REG_CTRL, {16'h0000, 5'h1F, 3'(k), c.thr});
      rd(RXEIF_REG_CTRL);
      chk("ctrl readback", d, {21'h0, 3'(k), c.thr});
      fifo_free <= th;
      repeat (3) @(posedge aclk);
      chk("pause at threshold", pause_tx_req, 1'b1);
      rd(RXEIF_REG_CTRL);
      chk("sent bit", d[18], 1'b1);
      fifo_free <= 12'hFFF;
    end
    // only lane 0 strobed: the code and the request bits must not move
    s_axi_wstrb <= 4'h1;
    wr(RXEIF_REG_CTRL, 32'h0003_0055);
    s_axi_wstrb <= 4'hF;
    rd(RXEIF_REG_CTRL);
    chk("lane strobe", d, 32'h0000_0755);
    $display("test threshold done");
    // software and descriptor pause requests, both undone by the clear bit
    wr(RXEIF_REG_CTRL, 32'h0002_0000);
    rd(RXEIF_REG_CTRL);
    chk("xoff set", d[18:16], 3'h6);
    chk("xoff drives req", pause_tx_req, 1'b1);
    wr(RXEIF_REG_CTRL, 32'h0001_0000);
    rd(RXEIF_REG_CTRL);
    chk("xon clear", d[18:16], 3'h0);
    @(posedge aclk);
    descriptor_pause_bit <= 1'b1;
    @(posedge aclk);
    descriptor_pause_bit <= 1'b0;
    rd(RXEIF_REG_CTRL);
    chk("descriptor req", d[17], 1'b1);
    wr(RXEIF_REG_CTRL, 32'h0001_0000);
    rd(RXEIF_REG_CTRL);
    chk("descriptor cleared", d[17], 1'b0);
    // a held-off clock enable must swallow a descriptor request
    clk_en <= 1'b0;
    @(posedge aclk);
    descriptor_pause_bit <= 1'b1;
    @(posedge aclk);
    descriptor_pause_bit <= 1'b0;
    clk_en <= 1'b1;
    rd(RXEIF_REG_CTRL);
    chk("frozen request", d[17], 1'b0);
    $display("test xoff done");
    // pause timers: zero value ignored, timer runs out on the third tick
    pulse(1'b0, 16'h0000);
    rd(RXEIF_REG_CTRL);
    chk("zero pause", d[20:19], 2'h0);
    pulse(1'b1, 16'h0005);
    rd(RXEIF_REG_CTRL);
    chk("pause low set", d[20], 1'b1);
    pulse(1'b0, 16'h0003);
    rd(RXEIF_REG_CTRL);
    chk("pause set low cleared", d[20:19], 2'h1);
    for (int k = 0; k < 3; k++) begin
      @(posedge aclk);
      pause_tick <= 1'b1;
      @(posedge aclk);
      pause_tick <= 1'b0;
      rd(RXEIF_REG_CTRL);
      chk("pause timer", d[19], k < 2);
    end
    $display("test pause done");
    // first frame after arming is the warm-up the block may skip
    receive_unit_ready <= 1'b1;
    wr(RXEIF_REG_CTRL, 32'h0000_0002);
    rxeif_rx_model_inst.send_frame(16'h002E, 16'h0000, 60, 1'b0, 0);
    wr(RXEIF_REG_STAT, 32'h0000_0003);
    // overflow held through a frame: no early event, the frame is still reported
    rx_overflow <= 1'b1;
    rxeif_rx_model_inst.send_frame(16'h002E, 16'h0000, 60, 1'b0, 0);
    rx_overflow <= 1'b0;
    repeat (4) @(posedge aclk);
    rd(RXEIF_REG_STAT);
    chk("overflow early", d[0], 1'b0);
    chk("overflow frame", d[1], 1'b1);
    wr(RXEIF_REG_STAT, 32'h0000_0003);
    $display("test overflow done");
    for (int k = 0; k < 11; k++) begin
      c = CASES[k];
      receive_unit_ready <= c.ru;
      wr(RXEIF_REG_CFG, {29'h0, c.cfg});
      wr(RXEIF_REG_CTRL, {24'h0, c.thr});
      n_recl = 0;
      rxeif_rx_model_inst.send_frame(c.tl, c.ipl, int'(c.n), c.bad, int'($urandom % 3));
      repeat (4) @(posedge aclk);
      rd(RXEIF_REG_STAT);
      chk("early flag", d[0], c.er);
      if (c.ru && !(c.bad && !c.cfg[2])) begin
        chk("frame flag", d[1], 1'b1);
        chk("irq line low", inta_n, 1'b0);
      end
      chk("reclaims", 32'(n_recl), 32'(c.bad && !c.cfg[2]));
      wr(RXEIF_REG_STAT, 32'h0000_0003);
      repeat (3) @(posedge aclk);
      chk("irq line released", inta_n, 1'b1);
    end
    $display("test frames done");
    // reset in mid-run must drop a standing request and the thresholds
    wr(RXEIF_REG_CTRL, 32'h0002_0703);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(RXEIF_REG_CTRL);
    chk("ctrl after reset", d, 32'h0);
    chk("req after reset", pause_tx_req, 1'b0);
    $display("test reset again done");
    end_of_test();
  end
endmodule
